// ---- lfs_pkg.sv ----
// Constants for the fan, sensor and glyph command handler
package lfs_pkg;
   localparam int CLK_HZ = 100_000_000;
   localparam int CLK_MHZ = CLK_HZ / 1_000_000;
   // Fan report slot and temperature report period
   localparam int FAN_SLOT_US = 125_000;
   localparam int FAN_SLOT_CYC = FAN_SLOT_US * CLK_MHZ;
   localparam int TEMP_PERIOD_MS = 1000;
   localparam int TEMP_PERIOD_CYC = TEMP_PERIOD_MS * 1000 * CLK_MHZ;
   // Command codes
   localparam logic [7:0] CMD_GLYPH = 8'h09;
   localparam logic [7:0] CMD_MEMRD = 8'h0a;
   localparam logic [7:0] CMD_CPOS = 8'h0b;
   localparam logic [7:0] CMD_CSTYLE = 8'h0c;
   localparam logic [7:0] CMD_CONTRAST = 8'h0d;
   localparam logic [7:0] CMD_BACKLIGHT = 8'h0e;
   localparam logic [7:0] CMD_FANREP = 8'h10;
   localparam logic [7:0] CMD_FANPWR = 8'h11;
   localparam logic [7:0] CMD_DEVINFO = 8'h12;
   localparam logic [7:0] CMD_TEMPREP = 8'h13;
   localparam logic [7:0] RSP_OK = 8'h40;
   localparam logic [7:0] RSP_ERR = 8'hc0;
   localparam logic [7:0] RSP_FANRPT = 8'h81;
   // Limits
   localparam logic [7:0] GLYPH_CNT = 8'h08;
   localparam logic [7:0] MEM_BASE = 8'h40;
   localparam logic [7:0] COL_CNT = 8'h14;
   localparam logic [7:0] ROW_CNT = 8'h04;
   localparam logic [7:0] STYLE_CNT = 8'h04;
   localparam logic [7:0] PWR_MAX = 8'h64;
   localparam logic [7:0] FAN_MASK_CNT = 8'h10;
   localparam logic [7:0] DEV_CNT = 8'h20;
   localparam logic [4:0] LEN_GLYPH = 5'h09;
   localparam logic [4:0] LEN_ONE = 5'h01;
   localparam logic [4:0] LEN_TWO = 5'h02;
   localparam logic [4:0] LEN_FOUR = 5'h04;
   localparam logic [4:0] LEN_MEM = 5'h09;
   localparam logic [4:0] LEN_NONE = 5'h00;
   localparam int BLINK_BIT = 7;
   localparam int SPARE_BIT = 6;
   // Register offsets
   localparam logic [7:0] REG_CTRL = 8'h00;
   localparam logic [7:0] REG_STATUS = 8'h04;
   localparam logic [7:0] REG_CURSOR = 8'h08;
   localparam logic [7:0] REG_LEVELS = 8'h0c;
   localparam logic [7:0] REG_FANPWR = 8'h10;
   localparam logic [7:0] REG_FANMASK = 8'h14;
   localparam logic [7:0] REG_TEMPMASK = 8'h18;
   localparam int CTRL_SAVE = 0;
   localparam int CTRL_LOAD = 1;
   localparam int CTRL_ENUM = 2;
   // Reset values of the boot image
   localparam logic [7:0] RST_CONTRAST = 8'h80;
   localparam logic [7:0] RST_BACKLIGHT = 8'h64;
   localparam logic [7:0] RST_FANPWR = 8'h64;
   typedef enum logic [0:0] {LFS_BOOT, LFS_RUN} lfs_state_t;
endpackage

// ---- lfs_cmd_handler.sv ----
// Glyph, cursor, level, fan and sensor bus command handler
//
// The placing of the registers and the strobed register port were left to the implementer.
`timescale 1ns/10ps
module lfs_cmd_handler #(
   parameter int FAN_SLOT_CYC = lfs_pkg::FAN_SLOT_CYC,
   parameter int TEMP_PERIOD_CYC = lfs_pkg::TEMP_PERIOD_CYC,
   // Family codes of the two supported sensor types; values are arbitrary
   parameter logic [7:0] TEMP_FAMILY_A = 8'h5a,
   parameter logic [7:0] TEMP_FAMILY_B = 8'h5b
) (
   input wire logic clk,
   input wire logic rstn,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic [7:0] cmd_type,
   input wire logic [4:0] cmd_len,
   input wire logic [127:0] cmd_data,
   output logic rsp_valid,
   input wire logic rsp_ready,
   output logic [7:0] rsp_type,
   output logic [4:0] rsp_len,
   output logic [71:0] rsp_data,
   input wire logic [7:0] reg_addr,
   input wire logic [31:0] reg_wdata,
   input wire logic reg_wr,
   input wire logic reg_rd,
   output logic [31:0] reg_rdata,
   input wire logic disp_wr,
   input wire logic [6:0] disp_wr_addr,
   input wire logic [7:0] disp_wr_data,
   input wire logic [5:0] glyph_rd_addr,
   output logic [5:0] glyph_rd_pix,
   output logic glyph_rd_blink,
   output logic [63:0] glyph_blink,
   output logic [4:0] cursor_col,
   output logic [1:0] cursor_row,
   output logic [1:0] cursor_style,
   output logic [7:0] contrast,
   output logic [7:0] backlight,
   output logic [23:0] fan_power,
   output logic [2:0] fan_force,
   output logic fan_rep_valid,
   output logic [1:0] fan_rep_idx,
   output logic [7:0] fan_rep_type,
   output logic enum_start,
   input wire logic enum_wr,
   input wire logic [4:0] enum_wr_idx,
   input wire logic [63:0] enum_wr_id,
   input wire logic enum_done,
   output logic temp_rep_valid,
   output logic [4:0] temp_rep_idx
);

   function automatic logic [7:0] byte_of(input logic [127:0] v, input int k);
      byte_of = v[8*k +: 8];
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // State
   lfs_pkg::lfs_state_t state_q;
   logic [7:0] glyph_q [64];
   logic [7:0] boot_glyph_q [64];
   logic [7:0] disp_q [128];
   logic [63:0] dev_id_q [32];
   logic [31:0] present_q;
   logic [4:0] col_q, boot_col_q;
   logic [1:0] row_q, boot_row_q, style_q, boot_style_q;
   logic [7:0] contrast_q, boot_contrast_q, backlight_q, boot_backlight_q;
   logic [7:0] fan_pwr_q [4];
   logic [7:0] boot_fan_pwr_q [4];
   logic [3:0] fan_mask_q;
   logic [31:0] temp_mask_q;
   logic enum_done_q, enum_start_q;
   logic [7:0] reject_cnt_q;
   logic rsp_valid_q;
   logic [7:0] rsp_type_q;
   logic [4:0] rsp_len_q;
   logic [71:0] rsp_data_q;
   logic [31:0] rdata_q;
   logic [5:0] pix_q;
   logic blink_q;
   logic [23:0] fan_out_q;
   logic [31:0] slot_cnt_q, sec_cnt_q;
   logic [1:0] slot_q;
   logic fan_rep_q;
   logic [1:0] fan_rep_idx_q;
   logic scan_q, temp_rep_q;
   logic [4:0] scan_idx_q, temp_idx_q;

   ////////////////////////////////////////////////////////////////////////////
   // Command decode and validation
   logic take, cmd_ok, load_boot, save_boot, restart_enum;
   logic [7:0] d0, d1;
   logic glyph_rows_ok, fan_pwr_ok;
   logic ok_glyph, ok_memrd, ok_cpos, ok_cstyle, ok_contrast, ok_backlight;
   logic ok_fanrep, ok_fanpwr, ok_devinfo, ok_temprep;
   logic [31:0] temp_ok, temp_req;
   logic [71:0] mem_reply, dev_reply;
   logic [7:0] mem_addr [8];

   assign take = cmd_valid && cmd_ready;
   assign d0 = byte_of(cmd_data, 0);
   assign d1 = byte_of(cmd_data, 1);
   assign save_boot = reg_wr && reg_addr == lfs_pkg::REG_CTRL && reg_wdata[lfs_pkg::CTRL_SAVE];
   assign restart_enum = reg_wr && reg_addr == lfs_pkg::REG_CTRL
      && reg_wdata[lfs_pkg::CTRL_ENUM];
   assign load_boot = state_q == lfs_pkg::LFS_BOOT
      || (reg_wr && reg_addr == lfs_pkg::REG_CTRL && reg_wdata[lfs_pkg::CTRL_LOAD]);

   always_comb begin
      glyph_rows_ok = 1'b1;
      for (int r = 1; r <= 8; r++) begin
         if (cmd_data[8*r + lfs_pkg::SPARE_BIT]) begin
            glyph_rows_ok = 1'b0;
         end
      end
      fan_pwr_ok = 1'b1;
      for (int f = 0; f < 4; f++) begin
         if (byte_of(cmd_data, f) > lfs_pkg::PWR_MAX) begin
            fan_pwr_ok = 1'b0;
         end
      end
   end

   always_comb begin
      for (int i = 0; i < 32; i++) begin
         temp_ok[i] = present_q[i] && (dev_id_q[i][7:0] == TEMP_FAMILY_A
            || dev_id_q[i][7:0] == TEMP_FAMILY_B);
      end
   end
   assign temp_req = cmd_data[31:0];

   assign ok_glyph = cmd_len == lfs_pkg::LEN_GLYPH && d0 < lfs_pkg::GLYPH_CNT
      && glyph_rows_ok;
   assign ok_memrd = cmd_len == lfs_pkg::LEN_ONE && d0 >= lfs_pkg::MEM_BASE;
   assign ok_cpos = cmd_len == lfs_pkg::LEN_TWO && d0 < lfs_pkg::COL_CNT
      && d1 < lfs_pkg::ROW_CNT;
   assign ok_cstyle = cmd_len == lfs_pkg::LEN_ONE && d0 < lfs_pkg::STYLE_CNT;
   assign ok_contrast = cmd_len == lfs_pkg::LEN_ONE;
   assign ok_backlight = cmd_len == lfs_pkg::LEN_ONE && d0 <= lfs_pkg::PWR_MAX;
   assign ok_fanrep = cmd_len == lfs_pkg::LEN_ONE && d0 < lfs_pkg::FAN_MASK_CNT;
   assign ok_fanpwr = cmd_len == lfs_pkg::LEN_FOUR && fan_pwr_ok;
   assign ok_devinfo = cmd_len == lfs_pkg::LEN_ONE && d0 < lfs_pkg::DEV_CNT;
   assign ok_temprep = cmd_len == lfs_pkg::LEN_FOUR && (temp_req & ~temp_ok) == 32'h0;

   always_comb begin
      case (cmd_type)
         lfs_pkg::CMD_GLYPH: cmd_ok = ok_glyph;
         lfs_pkg::CMD_MEMRD: cmd_ok = ok_memrd;
         lfs_pkg::CMD_CPOS: cmd_ok = ok_cpos;
         lfs_pkg::CMD_CSTYLE: cmd_ok = ok_cstyle;
         lfs_pkg::CMD_CONTRAST: cmd_ok = ok_contrast;
         lfs_pkg::CMD_BACKLIGHT: cmd_ok = ok_backlight;
         lfs_pkg::CMD_FANREP: cmd_ok = ok_fanrep;
         lfs_pkg::CMD_FANPWR: cmd_ok = ok_fanpwr;
         lfs_pkg::CMD_DEVINFO: cmd_ok = ok_devinfo;
         lfs_pkg::CMD_TEMPREP: cmd_ok = ok_temprep;
         default: cmd_ok = 1'b0;
      endcase
   end

   // Eight consecutive controller bytes from the requested address
   always_comb begin
      mem_reply[7:0] = d0;
      for (int k = 0; k < 8; k++) begin
         mem_addr[k] = d0 + 8'(k);
         mem_reply[8*k+8 +: 8] = mem_addr[k][7] ? disp_q[mem_addr[k][6:0]]
            : glyph_q[mem_addr[k][5:0]];
      end
   end
   assign dev_reply = {dev_id_q[d0[4:0]], d0};

   ////////////////////////////////////////////////////////////////////////////
   // Boot sequencing and reply
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         state_q <= lfs_pkg::LFS_BOOT;
      end else begin
         state_q <= lfs_pkg::LFS_RUN;
      end
   end
   assign cmd_ready = state_q == lfs_pkg::LFS_RUN && !rsp_valid_q;

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rsp_valid_q <= 1'b0;
         rsp_type_q <= 8'h00;
         rsp_len_q <= 5'h00;
         rsp_data_q <= 72'h0;
      end else if (take) begin
         rsp_valid_q <= 1'b1;
         rsp_type_q <= cmd_type | (cmd_ok ? lfs_pkg::RSP_OK : lfs_pkg::RSP_ERR);
         rsp_len_q <= lfs_pkg::LEN_NONE;
         rsp_data_q <= 72'h0;
         if (cmd_ok && cmd_type == lfs_pkg::CMD_MEMRD) begin
            rsp_len_q <= lfs_pkg::LEN_MEM;
            rsp_data_q <= mem_reply;
         end
         if (cmd_ok && cmd_type == lfs_pkg::CMD_DEVINFO) begin
            rsp_len_q <= lfs_pkg::LEN_MEM;
            rsp_data_q <= dev_reply;
         end
      end else if (rsp_ready) begin
         rsp_valid_q <= 1'b0;
      end
   end
   assign rsp_valid = rsp_valid_q;
   assign rsp_type = rsp_type_q;
   assign rsp_len = rsp_len_q;
   assign rsp_data = rsp_data_q;

   ////////////////////////////////////////////////////////////////////////////
   // Live settings and boot image
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         for (int i = 0; i < 64; i++) begin
            glyph_q[i] <= 8'h00;
            boot_glyph_q[i] <= 8'h00;
         end
         col_q <= 5'h00;
         row_q <= 2'h0;
         style_q <= 2'h0;
         contrast_q <= 8'h00;
         backlight_q <= 8'h00;
         boot_col_q <= 5'h00;
         boot_row_q <= 2'h0;
         boot_style_q <= 2'h0;
         boot_contrast_q <= lfs_pkg::RST_CONTRAST;
         boot_backlight_q <= lfs_pkg::RST_BACKLIGHT;
         for (int f = 0; f < 4; f++) begin
            fan_pwr_q[f] <= 8'h00;
            boot_fan_pwr_q[f] <= lfs_pkg::RST_FANPWR;
         end
         fan_mask_q <= 4'h0;
         temp_mask_q <= 32'h0;
         reject_cnt_q <= 8'h00;
      end else begin
         if (save_boot) begin
            boot_glyph_q <= glyph_q;
            boot_col_q <= col_q;
            boot_row_q <= row_q;
            boot_style_q <= style_q;
            boot_contrast_q <= contrast_q;
            boot_backlight_q <= backlight_q;
            boot_fan_pwr_q <= fan_pwr_q;
         end
         if (load_boot) begin
            glyph_q <= boot_glyph_q;
            col_q <= boot_col_q;
            row_q <= boot_row_q;
            style_q <= boot_style_q;
            contrast_q <= boot_contrast_q;
            backlight_q <= boot_backlight_q;
            fan_pwr_q <= boot_fan_pwr_q;
         end else if (take && cmd_ok) begin
            case (cmd_type)
               lfs_pkg::CMD_GLYPH: begin
                  for (int r = 0; r < 8; r++) begin
                     glyph_q[{d0[2:0], 3'(r)}] <= byte_of(cmd_data, r + 1);
                  end
               end
               lfs_pkg::CMD_CPOS: begin
                  col_q <= d0[4:0];
                  row_q <= d1[1:0];
               end
               lfs_pkg::CMD_CSTYLE: style_q <= d0[1:0];
               lfs_pkg::CMD_CONTRAST: contrast_q <= d0;
               lfs_pkg::CMD_BACKLIGHT: backlight_q <= d0;
               lfs_pkg::CMD_FANPWR: begin
                  for (int f = 0; f < 4; f++) begin
                     fan_pwr_q[f] <= byte_of(cmd_data, f);
                  end
               end
               default: begin
               end
            endcase
         end
         if (take && cmd_ok && cmd_type == lfs_pkg::CMD_FANREP) begin
            fan_mask_q <= d0[3:0];
         end
         if (restart_enum) begin
            temp_mask_q <= 32'h0;
         end else if (take && cmd_ok && cmd_type == lfs_pkg::CMD_TEMPREP) begin
            temp_mask_q <= temp_req;
         end
         if (take && !cmd_ok && reject_cnt_q != 8'hff) begin
            reject_cnt_q <= reject_cnt_q + 8'h01;
         end
      end
   end

   // Display RAM is written by the text commands outside this block
   always_ff @(posedge clk) begin
      if (disp_wr) begin
         disp_q[disp_wr_addr] <= disp_wr_data;
      end
   end

   always_comb begin
      for (int i = 0; i < 64; i++) begin
         glyph_blink[i] = glyph_q[i][lfs_pkg::BLINK_BIT];
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Sensor bus enumeration store
   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         present_q <= 32'h0;
         enum_done_q <= 1'b0;
         enum_start_q <= 1'b0;
         for (int i = 0; i < 32; i++) begin
            dev_id_q[i] <= 64'h0;
         end
      end else begin
         enum_start_q <= state_q == lfs_pkg::LFS_BOOT || restart_enum;
         if (restart_enum) begin
            present_q <= 32'h0;
            enum_done_q <= 1'b0;
         end
         if (enum_wr) begin
            dev_id_q[enum_wr_idx] <= enum_wr_id;
            present_q[enum_wr_idx] <= 1'b1;
         end
         if (enum_done) begin
            enum_done_q <= 1'b1;
         end
      end
   end
   assign enum_start = enum_start_q;

   ////////////////////////////////////////////////////////////////////////////
   // Fan report slots and temperature report scan
   logic slot_end, sec_end;
   assign slot_end = slot_cnt_q == 32'(FAN_SLOT_CYC - 1);
   assign sec_end = sec_cnt_q == 32'(TEMP_PERIOD_CYC - 1);

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         slot_cnt_q <= 32'h0;
         slot_q <= 2'h0;
         fan_rep_q <= 1'b0;
         fan_rep_idx_q <= 2'h0;
         sec_cnt_q <= 32'h0;
         scan_q <= 1'b0;
         scan_idx_q <= 5'h00;
         temp_rep_q <= 1'b0;
         temp_idx_q <= 5'h00;
      end else begin
         slot_cnt_q <= slot_end ? 32'h0 : slot_cnt_q + 32'h1;
         if (slot_end) begin
            slot_q <= slot_q + 2'h1;
         end
         fan_rep_q <= slot_end && fan_mask_q[slot_q + 2'h1];
         fan_rep_idx_q <= slot_q + 2'h1;
         sec_cnt_q <= sec_end ? 32'h0 : sec_cnt_q + 32'h1;
         if (sec_end) begin
            scan_q <= 1'b1;
            scan_idx_q <= 5'h00;
         end else if (scan_q) begin
            scan_idx_q <= scan_idx_q + 5'h01;
            scan_q <= scan_idx_q != 5'h1f;
         end
         temp_rep_q <= scan_q && temp_mask_q[scan_idx_q];
         temp_idx_q <= scan_idx_q;
      end
   end
   assign fan_rep_valid = fan_rep_q;
   assign fan_rep_idx = fan_rep_idx_q;
   assign fan_rep_type = lfs_pkg::RSP_FANRPT;
   assign temp_rep_valid = temp_rep_q;
   assign temp_rep_idx = temp_idx_q;

   always_comb begin
      for (int f = 0; f < 3; f++) begin
         fan_force[f] = fan_mask_q[f] && slot_q == 2'(f);
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Outputs and register port
   logic [31:0] rd_mux;
   always_comb begin
      case (reg_addr)
         lfs_pkg::REG_STATUS: rd_mux = {16'h0, reject_cnt_q, 7'h0, enum_done_q};
         lfs_pkg::REG_CURSOR: rd_mux = {19'h0, style_q, row_q, 4'h0, col_q};
         lfs_pkg::REG_LEVELS: rd_mux = {16'h0, backlight_q, contrast_q};
         lfs_pkg::REG_FANPWR: rd_mux = {fan_pwr_q[3], fan_pwr_q[2], fan_pwr_q[1], fan_pwr_q[0]};
         lfs_pkg::REG_FANMASK: rd_mux = {28'h0, fan_mask_q};
         lfs_pkg::REG_TEMPMASK: rd_mux = temp_mask_q;
         default: rd_mux = 32'h0;
      endcase
   end

   always_ff @(posedge clk or negedge rstn) begin
      if (!rstn) begin
         rdata_q <= 32'h0;
         pix_q <= 6'h00;
         blink_q <= 1'b0;
         fan_out_q <= 24'h0;
      end else begin
         rdata_q <= reg_rd ? rd_mux : 32'h0;
         pix_q <= glyph_q[glyph_rd_addr][5:0];
         blink_q <= glyph_q[glyph_rd_addr][lfs_pkg::BLINK_BIT];
         for (int f = 0; f < 3; f++) begin
            fan_out_q[8*f +: 8] <= fan_force[f] ? lfs_pkg::PWR_MAX : fan_pwr_q[f];
         end
      end
   end
   assign reg_rdata = rdata_q;
   assign glyph_rd_pix = pix_q;
   assign glyph_rd_blink = blink_q;
   assign fan_power = fan_out_q;
   assign cursor_col = col_q;
   assign cursor_row = row_q;
   assign cursor_style = style_q;
   assign contrast = contrast_q;
   assign backlight = backlight_q;

   ////////////////////////////////////////////////////////////////////////////
   // Checks
   a_reply_type: assert property (@(posedge clk) disable iff (!rstn)
      (take && cmd_ok) |=> (rsp_valid && rsp_type == ($past(cmd_type) | 8'h40)))
      else $error("accepted command reply type wrong");
   a_reject_state: assert property (@(posedge clk) disable iff (!rstn)
      (take && !cmd_ok && !reg_wr) |=> ($stable(contrast_q) && $stable(backlight_q)
      && $stable(col_q) && $stable(fan_mask_q) && rsp_type[7:6] == 2'b11))
      else $error("rejected command changed state");
   a_memrd_reply: assert property (@(posedge clk) disable iff (!rstn)
      (take && cmd_ok && cmd_type == 8'h0a) |=> (rsp_len == 5'h09
      && rsp_data[7:0] == $past(d0)))
      else $error("memory read reply malformed");
   a_cursor_move: assert property (@(posedge clk) disable iff (!rstn)
      (take && cmd_ok && cmd_type == 8'h0b && !load_boot) |=> (cursor_col == $past(d0[4:0])
      && cursor_row == $past(d1[1:0])))
      else $error("cursor not moved");
   a_fan_force: assert property (@(posedge clk) disable iff (!rstn)
      fan_force[0] |=> fan_power[7:0] == 8'h64)
      else $error("forced fan not at full power");
   a_fan_report: assert property (@(posedge clk) disable iff (!rstn)
      fan_rep_valid |-> ($past(fan_mask_q[fan_rep_idx]) && fan_rep_type == 8'h81))
      else $error("fan report for disabled fan");
   a_temp_report: assert property (@(posedge clk) disable iff (!rstn)
      temp_rep_valid |-> ($past(temp_mask_q[scan_idx_q]) && $past(temp_ok[scan_idx_q])))
      else $error("temperature report for disabled sensor");
   a_temp_support: assert property (@(posedge clk) disable iff (!rstn)
      (take && cmd_ok && cmd_type == 8'h13) |=> ((temp_mask_q & ~temp_ok) == 32'h0))
      else $error("unsupported sensor enabled");
   a_boot_enum: assert property (@(posedge clk) disable iff (!rstn)
      (state_q == lfs_pkg::LFS_BOOT) |=> enum_start ##1 !enum_start)
      else $error("enumeration not started at boot");
   a_dev_info: assert property (@(posedge clk) disable iff (!rstn)
      (take && cmd_ok && cmd_type == 8'h12) |=> (rsp_len == 5'h09
      && rsp_data[7:0] == $past(d0)))
      else $error("device info reply malformed");

endmodule

// ---- lfs_bus_model.sv ----
// Sensor bus enumerator and reply sink of the host
`timescale 1ns/10ps
module lfs_bus_model (
   input wire logic clk,
   input wire logic enum_start,
   output logic rsp_ready,
   output logic enum_wr,
   output logic [4:0] enum_wr_idx,
   output logic [63:0] enum_wr_id,
   output logic enum_done
);
   integer seed = 32'hb733;
   initial begin
      {enum_wr, enum_wr_idx, enum_wr_id, enum_done} = '0;
      forever begin
         @(negedge clk);
         if (enum_start === 1'b1) begin
            for (int i = 0; i < 4; i++) begin
               @(posedge clk);
               enum_wr <= 1'b1;
               enum_wr_idx <= 5'(i);
               enum_wr_id <= {8'(i * 5 + 1), 48'h0, i[0] ? 8'h5c : 8'h5a};
            end
            @(posedge clk);
            enum_wr <= 1'b0;
            enum_wr_id <= ~enum_wr_id;
            enum_done <= 1'b1;
            @(posedge clk);
            enum_done <= 1'b0;
         end
      end
   end
   // Replies are taken with random stalls
   always @(posedge clk) rsp_ready <= 1'($random(seed) & 1);
endmodule

// ---- lfs_cmd_handler_tb.sv ----
// Self-checking bench for the command handler
`timescale 1ns/10ps
module lfs_cmd_handler_tb;
   logic clk, rstn, cmd_valid, cmd_ready, rsp_valid, rsp_ready, reg_wr, reg_rd, glyph_rd_blink;
   logic fan_rep_valid, enum_start, enum_wr, enum_done, temp_rep_valid, disp_wr;
   logic [6:0] disp_wr_addr;
   logic [7:0] disp_wr_data;
   logic [7:0] cmd_type, rsp_type, reg_addr, contrast, backlight, fan_rep_type, c, rows [8];
   logic [4:0] cmd_len, rsp_len, cursor_col, enum_wr_idx, temp_rep_idx;
   logic [1:0] cursor_row, cursor_style, fan_rep_idx;
   logic [2:0] fan_force;
   logic [5:0] glyph_rd_addr, glyph_rd_pix;
   logic [23:0] fan_power;
   logic [31:0] reg_wdata, reg_rdata, rv;
   logic [63:0] glyph_blink, enum_wr_id, g;
   logic [71:0] rsp_data, rd;
   logic [127:0] cmd_data;
   integer seed = 32'hb733, n_errors = 0, compares = 0, fan_cnt = 0, n, frc_cnt = 0, m;
   lfs_cmd_handler #(.FAN_SLOT_CYC(16), .TEMP_PERIOD_CYC(64)) u_lfs_cmd_handler (.clk, .rstn,
      .cmd_valid, .cmd_ready, .cmd_type, .cmd_len, .cmd_data, .rsp_valid, .rsp_ready, .rsp_type,
      .rsp_len, .rsp_data, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .disp_wr,
      .disp_wr_addr, .disp_wr_data, .glyph_rd_addr, .glyph_rd_pix, .glyph_rd_blink,
      .glyph_blink, .cursor_col, .cursor_row, .cursor_style, .contrast, .backlight, .fan_power,
      .fan_force, .fan_rep_valid, .fan_rep_idx, .fan_rep_type, .enum_start, .enum_wr,
      .enum_wr_idx, .enum_wr_id, .enum_done, .temp_rep_valid, .temp_rep_idx);
   lfs_bus_model u_lfs_bus_model (.clk, .enum_start, .rsp_ready, .enum_wr, .enum_wr_idx,
      .enum_wr_id, .enum_done);
   initial begin
      clk = 0;
      forever #5 clk = ~clk;
   end
   always @(posedge clk) begin
      if (fan_rep_valid === 1'b1) begin
         fan_cnt <= fan_cnt + ((fan_rep_idx === 2'h0 && fan_rep_type === 8'h81) ? 1 : 99);
      end
      if (fan_force === 3'h1) frc_cnt <= frc_cnt + 1;
   end
   task chk(input logic [71:0] got, input logic [71:0] exp);
      compares++;
      if (got !== exp) begin
         n_errors++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   task results;
      $display("compares %0d n_errors %0d", compares, n_errors);
      if (n_errors == 0 && compares > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic wt(ref logic s);
      int i;
      for (i = 0; i < 99 && s !== 1'b1; i++) @(negedge clk);
      if (s !== 1'b1) begin
         n_errors++;
         results();
      end
   endtask
   task cmd(input logic [7:0] t, input logic [4:0] l, input logic [127:0] d, input logic [7:0] e);
      @(posedge clk);
      {cmd_type, cmd_len, cmd_data, cmd_valid} <= {t, l, d, 1'b1};
      @(negedge clk);
      wt(cmd_ready);
      @(posedge clk);
      cmd_valid <= 1'b0;
      @(negedge clk);
      wt(rsp_valid);
      rd = rsp_data;
      chk(rsp_type, e);
      chk(rsp_len, (e == 8'h4a || e == 8'h52) ? 5'h09 : 5'h00);
   endtask
   task rr(input logic [7:0] a);
      @(posedge clk);
      {reg_addr, reg_rd} <= {a, 1'b1};
      @(posedge clk);
      reg_rd <= 1'b0;
      #1 rv = reg_rdata;
   endtask
   task rw(input logic [7:0] a, input logic [31:0] v);
      @(posedge clk);
      {reg_addr, reg_wdata, reg_wr} <= {a, v, 1'b1};
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   initial begin
      {rstn, cmd_valid, reg_wr, reg_rd, cmd_type, cmd_len, cmd_data} = '0;
      {reg_addr, reg_wdata, glyph_rd_addr, disp_wr, disp_wr_addr, disp_wr_data} = '0;
      repeat (3) @(posedge clk);
      rstn <= 1'b1;
      repeat (3) @(negedge clk);
      chk({contrast, backlight, fan_power}, 40'h8064646464);
      c = 8'(($random(seed) & 255) % 20);
      cmd(8'h0b, 5'h02, {8'h03, c}, 8'h4b);
      chk({cursor_row, cursor_col}, {2'h3, c[4:0]});
      cmd(8'h0b, 5'h02, 16'h0014, 8'hcb);
      chk(cursor_col, c[4:0]);
      cmd(8'h0c, 5'h01, 8'h02, 8'h4c);
      chk(cursor_style, 2'h2);
      c = 8'($random(seed));
      cmd(8'h0d, 5'h01, c, 8'h4d);
      cmd(8'h0e, 5'h01, 8'h64, 8'h4e);
      cmd(8'h0e, 5'h01, 8'h65, 8'hce);
      rr(8'h0c);
      chk(rv, {16'h0, 8'h64, c});
      rr(8'h20);
      chk(rv, 0);
      rw(8'h00, 32'h1);
      cmd(8'h0d, 5'h01, ~c, 8'h4d);
      rw(8'h00, 32'h2);
      repeat (2) @(negedge clk);
      chk(contrast, c);
      $display("levels done");
      for (int r = 0; r < 8; r++) g[8*r +: 8] = 8'($random(seed)) & 8'h3f;
      g[47] = 1'b1;
      cmd(8'h09, 5'h09, {g, 8'h08}, 8'hc9);
      cmd(8'h09, 5'h09, {g, 8'h03}, 8'h49);
      chk(glyph_blink[31:24], 8'h20);
      @(posedge clk) glyph_rd_addr <= 6'h1d;
      repeat (2) @(negedge clk);
      chk({glyph_rd_blink, glyph_rd_pix}, {1'b1, g[45:40]});
      cmd(8'h0a, 5'h01, 8'h58, 8'h4a);
      chk(rd, {g, 8'h58});
      cmd(8'h0a, 5'h01, 8'h20, 8'hca);
      @(posedge clk) {disp_wr, disp_wr_data} <= {1'b1, c};
      @(posedge clk) disp_wr <= 1'b0;
      cmd(8'h0a, 5'h01, 8'h80, 8'h4a);
      chk(rd[15:0], {c, 8'h80});
      $display("glyph done");
      for (int f = 0; f < 4; f++) g[8*f +: 8] = 8'(($random(seed) & 255) % 101);
      cmd(8'h11, 5'h04, {8'h65, g[23:0]}, 8'hd1);
      cmd(8'h11, 5'h04, g[31:0], 8'h51);
      @(negedge clk);
      chk(fan_power, g[23:0]);
      cmd(8'h10, 5'h01, 8'h01, 8'h50);
      @(negedge clk);
      n = fan_cnt;
      m = frc_cnt;
      repeat (128) @(negedge clk);
      chk(fan_cnt - n, 2);
      chk(frc_cnt - m, 32);
      cmd(8'h10, 5'h01, 8'h00, 8'h50);
      $display("fan done");
      rw(8'h00, 32'h4);
      cmd(8'h12, 5'h01, 8'h02, 8'h52);
      chk(rd, {8'h0b, 48'h0, 8'h5a, 8'h02});
      cmd(8'h13, 5'h04, 32'h2, 8'hd3);
      cmd(8'h13, 5'h04, 32'h4, 8'h53);
      wt(temp_rep_valid);
      chk(temp_rep_idx, 5'h02);
      rr(8'h04);
      chk(rv, 32'h0601);
      $display("sensor done");
      results();
   end
endmodule
